//--- rtl/isrx_exec.v
`timescale 1ns/1ps

module isrx_exec (
    input  wire        I_SYS_CLK,
    input  wire        I_NRST,
    input  wire        I_POR_NRST,
    input  wire        I_INSN_VALID,
    input  wire [2:0]  I_INSN_OP,
    input  wire        I_INSN_PTR_SEL,
    input  wire        I_INSN_REL,
    input  wire [1:0]  I_INSN_MODE,
    input  wire [5:0]  I_INSN_OFFSET,
    input  wire [7:0]  I_WREG,
    input  wire [14:0] I_STACK_TOP,
    input  wire        I_HSEL,
    input  wire [1:0]  I_HTRANS,
    input  wire        I_HWRITE,
    input  wire [2:0]  I_HSIZE,
    input  wire [31:0] I_HADDR,
    input  wire [31:0] I_HWDATA,
    input  wire        I_HREADY,
    output reg         O_HREADYOUT,
    output reg         O_HRESP,
    output reg  [31:0] O_HRDATA,
    output reg         O_MEM_WE,
    output reg  [15:0] O_MEM_ADDR,
    output reg  [7:0]  O_MEM_WDATA,
    output reg         O_STACK_POP,
    output reg         O_PC_LOAD,
    output reg  [14:0] O_PC,
    output reg         O_BUSY,
    output reg         O_SW_RESET,
    output reg  [7:0]  O_OPTION,
    output reg         O_GIE
);
`include "isrx_defines.vh"

    // ------------------------------------------------------------
    // State encoding
    // ------------------------------------------------------------
    localparam [2:0] ST_RUN  = 3'h1;
    localparam [2:0] ST_RET2 = 3'h2;
    localparam [2:0] ST_RST  = 3'h4;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [15:0] pointer_reg [0:1];
    reg  [7:0]  option_reg;
    reg  [7:0]  irq_control_reg;
    reg         sw_reset_flag_n_reg;
    reg  [15:0] last_addr_reg;
    reg  [31:0] rd_data;
    reg  [15:0] eff_addr;
    reg  [15:0] ptr_new;
    reg         ptr_upd;
    wire        rd_take;
    wire        wr_pend_reg;
    wire [7:0]  wr_addr_reg;
    wire        issue;
    wire [15:0] ptr_cur;
    wire [15:0] ptr_inc;
    wire [15:0] ptr_dec;
    wire [15:0] ptr_rel;
    wire        is_store;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    isrx_ahb u_ahb (
        .i_clk         (I_SYS_CLK),
        .i_nrst        (I_NRST),
        .i_hsel        (I_HSEL),
        .i_htrans      (I_HTRANS),
        .i_hwrite      (I_HWRITE),
        .i_haddr       (I_HADDR[7:0]),
        .i_hready      (I_HREADY),
        .o_rd_take     (rd_take),
        .o_wr_pend_reg (wr_pend_reg),
        .o_wr_addr_reg (wr_addr_reg)
    );

    // ------------------------------------------------------------
    // Address arithmetic
    // ------------------------------------------------------------
    // Instructions arriving while busy or awaiting reset are dropped
    assign issue    = I_INSN_VALID & (state_reg == ST_RUN);
    assign is_store = issue & (I_INSN_OP == `ISRX_OP_STORE);
    assign ptr_cur  = pointer_reg[I_INSN_PTR_SEL];
    // 16-bit sums drop the carry, so the pointer wraps both ways
    assign ptr_inc  = ptr_cur + 16'h0001;
    assign ptr_dec  = ptr_cur - 16'h0001;
    assign ptr_rel  = ptr_cur + {{10{I_INSN_OFFSET[5]}}, I_INSN_OFFSET};

    always @* begin
        eff_addr = ptr_cur;
        ptr_new  = ptr_cur;
        ptr_upd  = 1'b0;
        if (I_INSN_REL) begin
            eff_addr = ptr_rel;
        end else begin
            ptr_upd = 1'b1;
            case (I_INSN_MODE)
                `ISRX_MODE_PREINC: begin
                    eff_addr = ptr_inc;
                    ptr_new  = ptr_inc;
                end
                `ISRX_MODE_PREDEC: begin
                    eff_addr = ptr_dec;
                    ptr_new  = ptr_dec;
                end
                `ISRX_MODE_POSTINC: begin
                    eff_addr = ptr_cur;
                    ptr_new  = ptr_inc;
                end
                default: begin
                    eff_addr = ptr_cur;
                    ptr_new  = ptr_dec;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (issue & ((I_INSN_OP == `ISRX_OP_RETIRQ) |
                             (I_INSN_OP == `ISRX_OP_RETSUB))) begin
                    state_next = ST_RET2;
                end else if (issue & (I_INSN_OP == `ISRX_OP_RESET)) begin
                    state_next = ST_RST;
                end
            end
            ST_RET2: begin
                state_next = ST_RUN;
            end
            ST_RST: begin
                // Held until the device reset comes back on I_NRST
                state_next = ST_RST;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            state_reg   <= ST_RUN;
            O_BUSY      <= 1'b0;
            O_STACK_POP <= 1'b0;
            O_PC_LOAD   <= 1'b0;
            O_PC        <= `ISRX_RST_PC;
            O_SW_RESET  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            // Second cycle of a return is a flush slot
            O_BUSY      <= (state_next != ST_RUN);
            O_STACK_POP <= (state_reg == ST_RUN) & (state_next == ST_RET2);
            O_PC_LOAD   <= (state_reg == ST_RUN) & (state_next == ST_RET2);
            if ((state_reg == ST_RUN) & (state_next == ST_RET2)) begin
                O_PC <= I_STACK_TOP;
            end
            O_SW_RESET  <= (state_reg == ST_RUN) & (state_next == ST_RST);
        end
    end

    // ------------------------------------------------------------
    // Data memory store port
    // ------------------------------------------------------------
    // No status flag output exists here, so no flag can move
    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            O_MEM_WE      <= 1'b0;
            O_MEM_ADDR    <= 16'h0000;
            O_MEM_WDATA   <= 8'h00;
            last_addr_reg <= 16'h0000;
        end else begin
            O_MEM_WE <= is_store;
            if (is_store) begin
                O_MEM_ADDR    <= eff_addr;
                O_MEM_WDATA   <= I_WREG;
                last_addr_reg <= eff_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Pointer registers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
            // Store update wins over a bus write in the same cycle
            always @(posedge I_SYS_CLK) begin
                if (!I_NRST) begin
                    pointer_reg[gi] <= `ISRX_RST_PTR;
                end else if (is_store & ptr_upd &
                             (I_INSN_PTR_SEL == (gi == 1))) begin
                    pointer_reg[gi] <= ptr_new;
                end else if (wr_pend_reg & (wr_addr_reg == ((gi == 1) ?
                             `ISRX_OFS_PTR1 : `ISRX_OFS_PTR0))) begin
                    pointer_reg[gi] <= I_HWDATA[15:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Option, interrupt control and power control
    // ------------------------------------------------------------
    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            option_reg      <= `ISRX_RST_OPTION;
            irq_control_reg <= `ISRX_RST_IRQCTL;
        end else begin
            if (issue & (I_INSN_OP == `ISRX_OP_OPTION)) begin
                option_reg <= I_WREG;
            end else if (wr_pend_reg & (wr_addr_reg == `ISRX_OFS_OPTION)) begin
                option_reg <= I_HWDATA[7:0];
            end
            if (wr_pend_reg & (wr_addr_reg == `ISRX_OFS_IRQCTL)) begin
                irq_control_reg <= I_HWDATA[7:0];
            end
            // Hardware set wins over a software clear, other bits still land
            if (issue & (I_INSN_OP == `ISRX_OP_RETIRQ)) begin
                irq_control_reg[`ISRX_GIE_BIT] <= 1'b1;
            end
        end
    end

    // Survives the device reset it triggers; power-on or a PWRCTL write with the SWRST bit set restores it
    always @(posedge I_SYS_CLK) begin
        if (!I_POR_NRST) begin
            sw_reset_flag_n_reg <= 1'b1;
        end else if (issue & (I_INSN_OP == `ISRX_OP_RESET)) begin
            sw_reset_flag_n_reg <= 1'b0;
        end else if (wr_pend_reg & (wr_addr_reg == `ISRX_OFS_PWRCTL) &
                     I_HWDATA[`ISRX_SWRST_BIT]) begin
            sw_reset_flag_n_reg <= 1'b1;
        end
    end

    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            O_OPTION <= `ISRX_RST_OPTION;
            O_GIE    <= 1'b0;
        end else begin
            O_OPTION <= option_reg;
            O_GIE    <= irq_control_reg[`ISRX_GIE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Bus read path
    // ------------------------------------------------------------
    // Limitation: a read right behind a write to one register sees old data
    always @* begin
        rd_data = 32'h0000_0000;
        case (I_HADDR[7:0])
            `ISRX_OFS_PTR0:     rd_data = {16'h0000, pointer_reg[0]};
            `ISRX_OFS_PTR1:     rd_data = {16'h0000, pointer_reg[1]};
            `ISRX_OFS_OPTION:   rd_data = {24'h000000, option_reg};
            `ISRX_OFS_PWRCTL:   rd_data = {31'h00000000, sw_reset_flag_n_reg};
            `ISRX_OFS_IRQCTL:   rd_data = {24'h000000, irq_control_reg};
            `ISRX_OFS_STATUS:   rd_data = {30'h00000000,
                                           (state_reg == ST_RST),
                                           (state_reg != ST_RUN)};
            `ISRX_OFS_LASTADDR: rd_data = {16'h0000, last_addr_reg};
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    always @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
            O_HRDATA    <= 32'h0000_0000;
        end else begin
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
            if (rd_take) begin
                O_HRDATA <= rd_data;
            end
        end
    end

endmodule // isrx_exec

//--- common/isrx_defines.vh
`ifndef ISRX_DEFINES_VH
`define ISRX_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISRX_OFS_PTR0       8'h00
`define ISRX_OFS_PTR1       8'h04
`define ISRX_OFS_OPTION     8'h08
`define ISRX_OFS_PWRCTL     8'h0c
`define ISRX_OFS_IRQCTL     8'h10
`define ISRX_OFS_STATUS     8'h14
`define ISRX_OFS_LASTADDR   8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISRX_GIE_BIT        7
`define ISRX_SWRST_BIT      0
`define ISRX_BUSY_BIT       0
`define ISRX_RSTREQ_BIT     1

// ----------------------------------------------------------------
// Instruction class codes on the issue port
// ----------------------------------------------------------------
`define ISRX_OP_NOP         3'h0
`define ISRX_OP_STORE       3'h1
`define ISRX_OP_OPTION      3'h2
`define ISRX_OP_RESET       3'h3
`define ISRX_OP_RETIRQ      3'h4
`define ISRX_OP_RETSUB      3'h5

// ----------------------------------------------------------------
// Addressing mode field codes
// ----------------------------------------------------------------
`define ISRX_MODE_PREINC    2'h0
`define ISRX_MODE_PREDEC    2'h1
`define ISRX_MODE_POSTINC   2'h2
`define ISRX_MODE_POSTDEC   2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ISRX_RST_PTR        16'h0000
`define ISRX_RST_OPTION     8'hff
`define ISRX_RST_IRQCTL     8'h00
`define ISRX_RST_PC         15'h0000

// ----------------------------------------------------------------
// AHB-Lite constants
// ----------------------------------------------------------------
`define ISRX_HTRANS_NONSEQ  2'h2
`define ISRX_HTRANS_SEQ     2'h3

`endif

//--- rtl/isrx_ahb.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// AHB-Lite front end: captures the address phase, zero wait states
// ----------------------------------------------------------------
module isrx_ahb (
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_hsel,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [7:0]  i_haddr,
    input  wire        i_hready,
    output wire        o_rd_take,
    output reg         o_wr_pend_reg,
    output reg  [7:0]  o_wr_addr_reg
);
`include "isrx_defines.vh"

    wire active;

    assign active = i_hsel & i_hready &
                    ((i_htrans == `ISRX_HTRANS_NONSEQ) |
                     (i_htrans == `ISRX_HTRANS_SEQ));
    // Read data is fetched at the address edge so it stands in data phase
    assign o_rd_take = active & ~i_hwrite;

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_wr_pend_reg <= 1'b0;
            o_wr_addr_reg <= 8'h00;
        end else begin
            o_wr_pend_reg <= active & i_hwrite;
            if (active & i_hwrite) begin
                o_wr_addr_reg <= i_haddr;
            end
        end
    end

endmodule // isrx_ahb

//--- test/isrx_checker.sv
`timescale 1ns/1ps
`include "isrx_defines.vh"
// ------------------------------------------------------------
// Port checker for the execution block
// ------------------------------------------------------------
module isrx_checker (
    input wire        I_SYS_CLK,
    input wire        I_NRST,
    input wire        I_INSN_VALID,
    input wire [2:0]  I_INSN_OP,
    input wire [7:0]  I_WREG,
    input wire [14:0] I_STACK_TOP,
    input wire        O_MEM_WE,
    input wire [7:0]  O_MEM_WDATA,
    input wire        O_STACK_POP,
    input wire        O_PC_LOAD,
    input wire [14:0] O_PC,
    input wire        O_BUSY,
    input wire        O_SW_RESET,
    input wire [7:0]  O_OPTION,
    input wire        O_GIE
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    // Busy cycles drop issue silently, so only idle issues count
    wire tk  = I_INSN_VALID && !O_BUSY;
    wire st  = tk && I_INSN_OP == `ISRX_OP_STORE;
    wire rti = tk && I_INSN_OP == `ISRX_OP_RETIRQ;
    wire ret = rti || (tk && I_INSN_OP == `ISRX_OP_RETSUB);
    sequence s_pop;
        O_STACK_POP && O_PC_LOAD && O_BUSY;
    endsequence
    sequence s_free;
        !O_STACK_POP && !O_PC_LOAD && !O_BUSY;
    endsequence
    a_store_write: assert property (st |=> O_MEM_WE &&
        O_MEM_WDATA == $past(I_WREG)) else $error("store data wrong");
    a_store_only: assert property (O_MEM_WE |-> $past(st))
        else $error("memory write without store");
    a_ret_pc: assert property (ret |=> O_PC == $past(I_STACK_TOP))
        else $error("return did not load stack top");
    a_ret_two_cyc: assert property (ret |=> s_pop ##1 s_free)
        else $error("return not two cycles");
    a_irq_enable: assert property (rti |=> ##1 O_GIE)
        else $error("irq enable not set");
    a_sw_reset: assert property (tk && I_INSN_OP == `ISRX_OP_RESET
        |=> O_SW_RESET ##1 !O_SW_RESET) else $error("reset pulse wrong");
    a_option_copy: assert property (tk &&
        I_INSN_OP == `ISRX_OP_OPTION |=> ##1 O_OPTION == $past(I_WREG, 2))
        else $error("option not loaded");
    a_nop_quiet: assert property (tk && I_INSN_OP == `ISRX_OP_NOP
        |=> !O_MEM_WE && !O_STACK_POP && !O_SW_RESET && !O_BUSY)
        else $error("nop had an effect");
endmodule // isrx_checker

bind isrx_exec isrx_checker u_chk (.*);

//--- test/isrx_exec_tb.sv
`timescale 1ns/1ps
`include "isrx_defines.vh"
// ------------------------------------------------------------
// Testbench; signal names match the ports for implicit hookup
// ------------------------------------------------------------
module isrx_exec_tb;
    logic        I_SYS_CLK = 0, I_NRST = 0, I_POR_NRST = 0;
    logic        I_INSN_VALID = 0, I_INSN_PTR_SEL = 0, I_INSN_REL = 0;
    logic        I_HSEL = 0, I_HWRITE = 0;
    logic [2:0]  I_INSN_OP = 0, I_HSIZE = 3'h2;
    logic [1:0]  I_INSN_MODE = 0, I_HTRANS = 0;
    logic [5:0]  I_INSN_OFFSET = 0;
    logic [7:0]  I_WREG = 0;
    logic [14:0] I_STACK_TOP = 0;
    logic [31:0] I_HADDR = 0, I_HWDATA = 0, rd;
    wire         I_HREADY, O_HREADYOUT, O_HRESP, O_MEM_WE, O_STACK_POP;
    wire         O_PC_LOAD, O_BUSY, O_SW_RESET, O_GIE;
    wire  [31:0] O_HRDATA;
    wire  [15:0] O_MEM_ADDR;
    wire  [7:0]  O_MEM_WDATA, O_OPTION;
    wire  [14:0] O_PC;
    int          mismatches = 0, n_compared = 0, cyc = 0;

    assign I_HREADY = O_HREADYOUT;
    isrx_exec dut (.*);

    initial begin
        forever #20 I_SYS_CLK = ~I_SYS_CLK;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge I_SYS_CLK) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            finish_test;
        end
    end
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_SYS_CLK);
        I_HSEL <= 1'b1;
        I_HTRANS <= `ISRX_HTRANS_NONSEQ;
        I_HWRITE <= w;
        I_HADDR <= {24'h0, a};
        do @(posedge I_SYS_CLK); while (I_HREADY !== 1'b1);
        I_HSEL <= 1'b0;
        I_HTRANS <= 2'h0;
        I_HWDATA <= d;
        do @(posedge I_SYS_CLK); while (I_HREADY !== 1'b1);
        rd = O_HRDATA;
    endtask
    // Holding valid for n edges probes the busy-cycle refusal
    task insn(input logic [2:0] op, input logic s, input logic r,
              input logic [1:0] m, input logic [5:0] k, input int n);
        @(posedge I_SYS_CLK);
        I_INSN_VALID <= 1'b1;
        I_INSN_OP <= op;
        I_INSN_PTR_SEL <= s;
        I_INSN_REL <= r;
        I_INSN_MODE <= m;
        I_INSN_OFFSET <= k;
        repeat (n) @(posedge I_SYS_CLK);
        I_INSN_VALID <= 1'b0;
        #1;
    endtask
    task st(input logic s, input logic r, input logic [1:0] m,
            input logic [5:0] k, input logic [15:0] p);
        logic [15:0] e;
        logic [15:0] q;
        logic [7:0]  o;
        o = s ? `ISRX_OFS_PTR1 : `ISRX_OFS_PTR0;
        e = r ? p + {{10{k[5]}}, k} : m == 2'h0 ? p + 16'h1 :
            m == 2'h1 ? p - 16'h1 : p;
        // Worked at 16 bits so the expected pointer wraps like the hardware
        q = r ? p : m[0] ? p - 16'h1 : p + 16'h1;
        ahb(1'b1, o, {16'h0, p});
        I_WREG <= p[7:0] ^ 8'h5a;
        insn(`ISRX_OP_STORE, s, r, m, k, 1);
        chk("we", 1, O_MEM_WE);
        chk("wdata", p[7:0] ^ 8'h5a, O_MEM_WDATA);
        chk("addr", e, O_MEM_ADDR);
        ahb(1'b0, o, 0);
        chk("ptr", q, rd);
        ahb(1'b0, `ISRX_OFS_LASTADDR, 0);
        chk("last", e, rd);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge I_SYS_CLK);
        I_NRST <= 1'b1;
        I_POR_NRST <= 1'b1;
        ahb(1'b0, `ISRX_OFS_PWRCTL, 0);
        chk("flag", 1, rd);
        ahb(1'b1, 8'h1c, 32'h5);
        ahb(1'b0, 8'h1c, 0);
        chk("unmapped", 0, rd);
        chk("hresp", 0, O_HRESP);
        st(0, 0, `ISRX_MODE_PREINC, 6'h00, 16'hffff);
        st(1, 0, `ISRX_MODE_PREDEC, 6'h00, 16'h0000);
        st(0, 0, `ISRX_MODE_POSTINC, 6'h00, 16'hffff);
        st(1, 0, `ISRX_MODE_POSTDEC, 6'h00, 16'h0000);
        st(0, 1, `ISRX_MODE_PREINC, 6'h20, 16'h0010);
        st(1, 1, `ISRX_MODE_POSTDEC, 6'h1f, 16'hffff);
        ahb(1'b0, `ISRX_OFS_IRQCTL, 0);
        chk("irqctl", 0, rd);
        insn(`ISRX_OP_NOP, 0, 0, 0, 0, 1);
        chk("nop pc", 0, O_PC);
        chk("nop we", 0, O_MEM_WE);
        chk("nop busy", 0, O_BUSY);
        ahb(1'b0, `ISRX_OFS_PTR0, 0);
        chk("nop ptr", 16'h0010, rd);
        I_WREG <= 8'h4f;
        insn(`ISRX_OP_OPTION, 0, 0, 0, 0, 1);
        @(posedge I_SYS_CLK);
        #1;
        chk("option", 8'h4f, O_OPTION);
        ahb(1'b0, `ISRX_OFS_OPTION, 0);
        chk("option reg", 8'h4f, rd);
        I_STACK_TOP <= 15'h1234;
        insn(`ISRX_OP_RETSUB, 0, 0, 0, 0, 2);
        chk("pc", 15'h1234, O_PC);
        chk("second pop", 0, O_STACK_POP);
        chk("busy", 0, O_BUSY);
        I_STACK_TOP <= 15'h7abc;
        insn(`ISRX_OP_RETIRQ, 0, 0, 0, 0, 1);
        chk("pop", 1, O_STACK_POP);
        chk("pc load", 1, O_PC_LOAD);
        chk("irq pc", 15'h7abc, O_PC);
        @(posedge I_SYS_CLK);
        #1;
        chk("gie", 1, O_GIE);
        ahb(1'b0, `ISRX_OFS_IRQCTL, 0);
        chk("irqctl gie", 32'h80, rd);
        insn(`ISRX_OP_RESET, 0, 0, 0, 0, 1);
        chk("swreset", 1, O_SW_RESET);
        ahb(1'b0, `ISRX_OFS_PWRCTL, 0);
        chk("flag clr", 0, rd);
        ahb(1'b0, `ISRX_OFS_STATUS, 0);
        chk("status", 32'h3, rd);
        I_WREG <= 8'h11;
        insn(`ISRX_OP_OPTION, 0, 0, 0, 0, 1);
        repeat (2) @(posedge I_SYS_CLK);
        #1;
        chk("stalled", 8'h4f, O_OPTION);
        @(posedge I_SYS_CLK);
        I_NRST <= 1'b0;
        @(posedge I_SYS_CLK);
        I_NRST <= 1'b1;
        ahb(1'b0, `ISRX_OFS_PWRCTL, 0);
        chk("flag kept", 0, rd);
        chk("busy rst", 0, O_BUSY);
        chk("opt rst", 8'hff, O_OPTION);
        I_POR_NRST <= 1'b0;
        @(posedge I_SYS_CLK);
        I_POR_NRST <= 1'b1;
        ahb(1'b0, `ISRX_OFS_PWRCTL, 0);
        chk("flag por", 1, rd);
        finish_test;
    end
endmodule // isrx_exec_tb
